/* src/kms_top.v */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "kms_regs.vh"

// Functional notes
// - matrix up to eighteen rows by eight columns; unused lines masked by firmware.
// - eight column sense inputs receive the matrix column lines.
// - eighteen row drive outputs drive the matrix row lines.
// - all scan logic runs from the single block clock.
// - system reset returns every register and all logic to defaults.
// - block drops to low power whenever no scan activity is going on.
// - scan-disable set holds the block in low power.
// - sleep-inhibit request raised while scanning, dropped once in low power.
// - with predrive on, rows are driven high before release to open drain.
// - column falling-edge detection and interrupt need no running bus clock.
// - each column has a status bit set on its high-to-low edge.
// - column interrupt only while status and enable both set.
// - writing one clears a status bit; zero leaves it.
// - column requests ORed into one active-high level runtime interrupt.
// - no reassertion until all columns high again or enables change.
// - bus clock stopped plus enabled falling edge raises wake request.
// - wake request stays asserted until the bus clock restarts.
// - sleep edges set status; runtime interrupt follows once clock resumes.
// - enabled, no invert, no drive-all: selected row low, others high.
// - scan-disable, the reset value, turns off all row buffers.
// - column level register reads present column pin levels.
module kms_top (
    // clock, reset, enable
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // matrix pins
    input wire [7:0] column_sense_in,
    output reg [17:0] row_drive_out,
    output reg [17:0] row_drive_oe,
    // power management
    input wire bus_clk_stopped,
    output wire sleep_inhibit,
    output wire matrix_runtime_irq,
    output wire matrix_wake_irq,
    output reg matrix_wake_request
);

// =====================================================================
// register bus
reg dph_wr;
reg [5:0] dph_addr;
reg [7:0] row_sel;
reg [7:0] col_sts;
reg [7:0] col_ien;
reg pre_en;
wire addr_ok;
wire [7:0] col_lvl;
reg [7:0] rd_word;

// decode shared by read mux and write strobes
function sel_is;
    input [5:0] a;
    input [5:0] ofs;
    begin
        sel_is = (a == ofs);
    end
endfunction

// the master waits through a frozen clock instead of losing a transfer
assign hreadyout = clk_en;
assign hresp = `KMS_HRESP_OKAY;
assign addr_ok = hsel & hready & (htrans == `KMS_HTRANS_NONSEQ);

// unmapped offsets read as zero
always @* begin
    rd_word = 8'h00;
    if (sel_is(haddr[5:0], `KMS_OFS_ROW_SEL)) begin
        rd_word = row_sel;
    end else if (sel_is(haddr[5:0], `KMS_OFS_COL_LVL)) begin
        rd_word = col_lvl;
    end else if (sel_is(haddr[5:0], `KMS_OFS_COL_STS)) begin
        rd_word = col_sts;
    end else if (sel_is(haddr[5:0], `KMS_OFS_COL_IEN)) begin
        rd_word = col_ien;
    end else if (sel_is(haddr[5:0], `KMS_OFS_EXT_CTL)) begin
        rd_word = {7'h00, pre_en};
    end
end

reg [31:0] next_hrdata;

// read data is taken in the address phase and stands until the next read
always @* begin
    next_hrdata = hrdata;
    if (addr_ok & ~hwrite) begin
        next_hrdata = {24'h000000, rd_word};
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dph_wr <= 1'b0;
        dph_addr <= `KMS_OFS_RST;
        hrdata <= `KMS_RD_RST;
    end else if (clk_en) begin
        dph_wr <= addr_ok & hwrite;
        dph_addr <= haddr[5:0];
        hrdata <= next_hrdata;
    end
end

// write strobes decode the address held over from the address phase
wire wr_row = dph_wr & sel_is(dph_addr, `KMS_OFS_ROW_SEL);
wire wr_sts = dph_wr & sel_is(dph_addr, `KMS_OFS_COL_STS);
wire wr_ien = dph_wr & sel_is(dph_addr, `KMS_OFS_COL_IEN);
wire wr_ext = dph_wr & sel_is(dph_addr, `KMS_OFS_EXT_CTL);

reg [7:0] next_row_sel;
reg [7:0] next_col_ien;
reg next_pre_en;

// a write lands at the data-phase edge, so a read right behind it
// still returns the old value
always @* begin
    next_row_sel = row_sel;
    next_col_ien = col_ien;
    next_pre_en = pre_en;
    if (wr_row) begin
        next_row_sel = hwdata[7:0];
    end
    if (wr_ien) begin
        next_col_ien = hwdata[7:0];
    end
    if (wr_ext) begin
        next_pre_en = hwdata[`KMS_PRE_BIT];
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        row_sel <= `KMS_ROW_SEL_RST;
        col_ien <= `KMS_COL_RST;
        pre_en <= `KMS_PRE_RST;
    end else if (clk_en) begin
        row_sel <= next_row_sel;
        col_ien <= next_col_ien;
        pre_en <= next_pre_en;
    end
end

// =====================================================================
// column synchronisers and edge detection
reg [7:0] col_s1;
reg [7:0] col_s2;
reg [7:0] col_s3;
wire [7:0] col_fall;

// a pulse shorter than one clock can slip between samples
// the first stage feeds only the second stage
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        col_s1 <= `KMS_COL_HIGH;
        col_s2 <= `KMS_COL_HIGH;
        col_s3 <= `KMS_COL_HIGH;
    end else if (clk_en) begin
        col_s1 <= column_sense_in;
        col_s2 <= col_s1;
        col_s3 <= col_s2;
    end
end

assign col_lvl = col_s2;
assign col_fall = col_s3 & ~col_s2;

// =====================================================================
// status, runtime and wake interrupts
wire [7:0] next_sts;
wire [7:0] col_req;
wire irq_level;
reg irq_blocked;
reg irq_seen;

// set beats a simultaneous write-one clear
genvar gc;
generate
    for (gc = 0; gc < `KMS_COLS; gc = gc + 1) begin : g_sts
        assign next_sts[gc] = col_fall[gc] |
            (col_sts[gc] & ~(wr_sts & hwdata[gc]));
    end
endgenerate

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        col_sts <= `KMS_COL_RST;
    end else if (clk_en) begin
        col_sts <= next_sts;
    end
end

// level request: drops as soon as status or enable clears
assign col_req = col_sts & col_ien;
assign irq_level = |col_req;

// once a request has been served, hold off until the keys are released
// or the enables are rewritten to a new value
reg next_irq_seen;
reg next_irq_blocked;
wire irq_rearm = (col_s2 == `KMS_COL_HIGH) | (wr_ien & (hwdata[7:0] != col_ien));

always @* begin
    next_irq_seen = irq_seen;
    next_irq_blocked = irq_blocked;
    if (irq_rearm) begin
        next_irq_blocked = 1'b0;
        next_irq_seen = 1'b0;
    end else if (matrix_runtime_irq) begin
        next_irq_seen = 1'b1;
    end else if (irq_seen & ~irq_level) begin
        next_irq_blocked = 1'b1;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_seen <= 1'b0;
        irq_blocked <= 1'b0;
    end else if (clk_en) begin
        irq_seen <= next_irq_seen;
        irq_blocked <= next_irq_blocked;
    end
end

// runtime request waits for the bus clock to run again
assign matrix_runtime_irq = irq_level & ~irq_blocked & ~bus_clk_stopped;

assign matrix_wake_irq = matrix_wake_request;

reg next_wake;

// the request is held in flops, so it needs hclk even while the
// bus clock is stopped
always @* begin
    next_wake = matrix_wake_request;
    if (bus_clk_stopped & |(col_fall & col_ien)) begin
        next_wake = 1'b1;
    end else if (~bus_clk_stopped) begin
        next_wake = 1'b0;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        matrix_wake_request <= 1'b0;
    end else if (clk_en) begin
        matrix_wake_request <= next_wake;
    end
end

// =====================================================================
// row drive
localparam [7:0] PRE_CYC = `KMS_PRE_CYC;

wire scan_dis = row_sel[`KMS_DIS_BIT];
wire row_inv = row_sel[`KMS_INV_BIT];
wire row_all = row_sel[`KMS_ALL_BIT];
wire [4:0] row_idx = row_sel[`KMS_IDX_MSB:`KMS_IDX_LSB];
wire [17:0] row_val;
reg [17:0] row_prev;
reg [7:0] pre_cnt;
reg [17:0] pre_rows;
wire [17:0] row_rise;
wire pre_start;
reg [7:0] next_pre_cnt;
reg [17:0] next_pre_rows;
reg [17:0] next_oe;

// row decode; indexes past the last row select nothing
function row_is;
    input [4:0] idx;
    input integer n;
    begin
        row_is = (idx <= `KMS_ROW_MAX) & (idx == n[4:0]);
    end
endfunction

// value a row would take if driven; selected row is the active one
genvar gr;
generate
    for (gr = 0; gr < `KMS_ROWS; gr = gr + 1) begin : g_row
        wire hit;
        assign hit = ~row_all & row_is(row_idx, gr);
        assign row_val[gr] = hit ? row_inv : ~row_inv;
    end
endgenerate

// in open-drain use only lows are driven; predrive briefly drives
// a rising row high so the line does not wait on the pull-up
assign row_rise = row_val & ~row_prev;
assign pre_start = pre_en & ~scan_dis & (|row_rise);

always @* begin
    next_pre_rows = pre_rows;
    next_pre_cnt = pre_cnt;
    if (pre_start) begin
        next_pre_rows = row_rise;
        next_pre_cnt = PRE_CYC;
    end else if (pre_cnt != `KMS_CNT_ZERO) begin
        next_pre_cnt = pre_cnt - 8'h01;
    end else begin
        next_pre_rows = `KMS_ROWS_OFF;
    end
end

// with invert and predrive the pads are push-pull, so the selected
// high row is driven as well
always @* begin
    next_oe = `KMS_ROWS_OFF;
    if (scan_dis) begin
        next_oe = `KMS_ROWS_OFF;
    end else begin
        next_oe = ~row_val;
        if (pre_en & row_inv) begin
            next_oe = next_oe | row_val;
        end
        if (pre_en) begin
            next_oe = next_oe | pre_rows;
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        row_prev <= `KMS_ROWS_HIGH;
        pre_rows <= `KMS_ROWS_OFF;
        pre_cnt <= `KMS_CNT_ZERO;
    end else if (clk_en) begin
        row_prev <= row_val;
        pre_rows <= next_pre_rows;
        pre_cnt <= next_pre_cnt;
    end
end

// pads see registered values only, never decode glitches
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        row_drive_out <= `KMS_ROWS_OFF;
        row_drive_oe <= `KMS_ROWS_OFF;
    end else if (clk_en) begin
        row_drive_out <= row_val;
        row_drive_oe <= next_oe;
    end
end

// =====================================================================
// power state: active only while a row is pulled or predrive runs;
// a press while hclk is stopped is caught only once the clock returns
wire rows_driven = |row_drive_oe;
wire pre_busy = pre_cnt != `KMS_CNT_ZERO;

assign sleep_inhibit = ~scan_dis & (rows_driven | pre_busy);

endmodule

/* shared/kms_regs.vh */
`ifndef KMS_REGS_VH
`define KMS_REGS_VH

// =====================================================================
// register byte offsets
`define KMS_OFS_ROW_SEL 6'h04
`define KMS_OFS_COL_LVL 6'h08
`define KMS_OFS_COL_STS 6'h0C
`define KMS_OFS_COL_IEN 6'h10
`define KMS_OFS_EXT_CTL 6'h14

// =====================================================================
// row_drive_select fields
`define KMS_IDX_LSB 0
`define KMS_IDX_MSB 4
`define KMS_ALL_BIT 5
`define KMS_DIS_BIT 6
`define KMS_INV_BIT 7
`define KMS_ROW_SEL_RST 8'h40

// scan_extended_control fields
`define KMS_PRE_BIT 0

// =====================================================================
// matrix size and timing
`define KMS_ROWS 18
`define KMS_COLS 8
`define KMS_ROW_MAX 5'h11
`define KMS_COL_HIGH 8'hFF
`define KMS_PRE_NS 20
`define KMS_CLK_MHZ 100
// predrive window in clocks: 20 ns at 100 MHz, rounded up
`define KMS_PRE_CYC 8'h02
`define KMS_CNT_ZERO 8'h00

// reset values
`define KMS_ROWS_HIGH 18'h3FFFF
`define KMS_ROWS_OFF 18'h00000
`define KMS_COL_RST 8'h00
`define KMS_PRE_RST 1'h0
`define KMS_OFS_RST 6'h00
`define KMS_RD_RST 32'h00000000

// ahb encodings
`define KMS_HTRANS_NONSEQ 2'h2
`define KMS_HSIZE_WORD 3'h2
`define KMS_HRESP_OKAY 1'h0

`endif

/* sim/kms_checker.sv */
`timescale 1ns/100ps
// ====================
// port checker
module kms_checker (
    // clock, reset, bus
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    // matrix and power
    input wire [7:0] column_sense_in,
    input wire [17:0] row_drive_oe,
    input wire bus_clk_stopped,
    input wire sleep_inhibit,
    input wire matrix_runtime_irq,
    input wire matrix_wake_irq,
    input wire matrix_wake_request
);
    reg [7:0] col_d1;
    reg [7:0] col_d2;
    wire rd_lvl = hsel && hready && clk_en && htrans == 2'h2 && !hwrite && haddr[5:0] == 6'h08;
    // pins held steady through the synchroniser depth
    always @(posedge hclk) begin
        col_d1 <= column_sense_in;
        col_d2 <= col_d1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RST_VALUES: assert property ($rose(hresetn) |-> row_drive_oe == 18'h0 && hrdata == 32'h0)
        else $error("reset value");
    AST_IDLE_ROWS: assert property (!sleep_inhibit [*2] |-> row_drive_oe == 18'h0)
        else $error("rows driven while idle");
    AST_WAKE_IRQ: assert property (matrix_wake_irq == matrix_wake_request)
        else $error("wake irq");
    AST_WAKE_CAUSE: assert property ($rose(matrix_wake_request) |-> $past(bus_clk_stopped))
        else $error("wake while awake");
    AST_WAKE_HOLD: assert property (matrix_wake_request && bus_clk_stopped |=> matrix_wake_request)
        else $error("wake dropped");
    AST_WAKE_DROP: assert property ((!bus_clk_stopped && clk_en) [*2] |-> !matrix_wake_request)
        else $error("wake stuck");
    AST_IRQ_MASK: assert property (bus_clk_stopped |-> !matrix_runtime_irq)
        else $error("irq in sleep");
    AST_LEVEL_READ: assert property (rd_lvl && col_d1 == column_sense_in && col_d2 == column_sense_in
        |=> hrdata == {24'h0, col_d2})
        else $error("level read");
endmodule
bind kms_top kms_checker i_kms_checker (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .column_sense_in(column_sense_in), .row_drive_oe(row_drive_oe), .bus_clk_stopped(bus_clk_stopped),
    .sleep_inhibit(sleep_inhibit), .matrix_runtime_irq(matrix_runtime_irq),
    .matrix_wake_irq(matrix_wake_irq), .matrix_wake_request(matrix_wake_request));

/* sim/kms_matrix.sv */
`timescale 1ns/100ps
// ====================
// passive switch matrix, one key
module kms_matrix (
    // rows
    input wire [17:0] row_drive_out,
    input wire [17:0] row_drive_oe,
    // key
    input wire key_down,
    input wire [4:0] key_row,
    input wire [2:0] key_col,
    // columns
    output wire [7:0] column_sense_in
);
    // released rows and columns float up on their pull-ups
    wire [17:0] row_level = row_drive_out | ~row_drive_oe;
    wire hit = key_down && !row_level[key_row];
    assign column_sense_in = ~({7'h0, hit} << key_col);
endmodule

/* sim/kms_top_bench.sv */
`timescale 1ns/100ps
`include "kms_regs.vh"
module kms_top_bench;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg clk_en = 1'b1;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg bus_clk_stopped = 1'b0;
    reg key_down = 1'b0;
    wire hreadyout, hresp, sleep_inhibit, matrix_runtime_irq, matrix_wake_irq, matrix_wake_request;
    wire [31:0] hrdata;
    wire [7:0] column_sense_in;
    wire [17:0] row_drive_out, row_drive_oe;
    integer num_errors = 0;
    integer num_checks = 0;
    integer cycles = 0;
    integer i;
    integer seen;
    reg [31:0] q;
    // control byte, row levels, column levels (key at row 5, column 3)
    reg [33:0] rows [0:6];
    kms_top i_kms_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(`KMS_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .column_sense_in(column_sense_in),
        .row_drive_out(row_drive_out), .row_drive_oe(row_drive_oe), .bus_clk_stopped(bus_clk_stopped),
        .sleep_inhibit(sleep_inhibit), .matrix_runtime_irq(matrix_runtime_irq),
        .matrix_wake_irq(matrix_wake_irq), .matrix_wake_request(matrix_wake_request));
    kms_matrix i_kms_matrix (.row_drive_out(row_drive_out), .row_drive_oe(row_drive_oe),
        .key_down(key_down), .key_row(5'h05), .key_col(3'h3), .column_sense_in(column_sense_in));
    // ====================
    // clock, timeout, tasks
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    task xfer(input [5:0] a, input w, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {26'h0, a};
            htrans <= `KMS_HTRANS_NONSEQ;
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            q = hrdata;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ====================
    // sequence
    initial begin
        rows[0] = {8'h00, 18'h3FFFE, 8'hFF};
        rows[1] = {8'h11, 18'h1FFFF, 8'hFF};
        rows[2] = {8'h12, 18'h3FFFF, 8'hFF};
        rows[3] = {8'h05, 18'h3FFDF, 8'hF7};
        rows[4] = {8'h85, 18'h00020, 8'hFF};
        rows[5] = {8'h20, 18'h3FFFF, 8'hFF};
        rows[6] = {8'hA0, 18'h00000, 8'hF7};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({14'h0, row_drive_oe}, 32'h0);
        for (i = 0; i < 7; i = i + 1) begin
            xfer(6'(4 * i), 1'b0, 32'h0);
            chk(q, (i == 1) ? 32'h40 : (i == 2) ? 32'hFF : 32'h0);
        end
        chk({30'h0, matrix_runtime_irq, sleep_inhibit}, 32'h0);
        $display("reset values done");
        key_down <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            xfer(`KMS_OFS_ROW_SEL, 1'b1, {24'h0, rows[i][33:26]});
            repeat (4) @(posedge hclk);
            chk({14'h0, row_drive_out | ~row_drive_oe}, {14'h0, rows[i][25:8]});
            chk({14'h0, row_drive_oe}, {14'h0, ~rows[i][25:8]});
            xfer(`KMS_OFS_COL_LVL, 1'b0, 32'h0);
            chk(q, {24'h0, rows[i][7:0]});
        end
        chk({31'h0, sleep_inhibit}, 32'h1);
        $display("row table done");
        xfer(`KMS_OFS_COL_STS, 1'b1, 32'h0);
        xfer(`KMS_OFS_COL_STS, 1'b0, 32'h0);
        chk(q, 32'h08);
        xfer(`KMS_OFS_COL_IEN, 1'b1, 32'h08);
        @(posedge hclk);
        chk({31'h0, matrix_runtime_irq}, 32'h1);
        xfer(`KMS_OFS_COL_STS, 1'b1, 32'h08);
        xfer(`KMS_OFS_COL_STS, 1'b0, 32'h0);
        chk({q[31:1], matrix_runtime_irq}, 32'h0);
        $display("status test done");
        key_down <= 1'b0;
        repeat (4) @(posedge hclk);
        bus_clk_stopped <= 1'b1;
        key_down <= 1'b1;
        repeat (6) @(posedge hclk);
        chk({29'h0, matrix_wake_irq, matrix_wake_request, matrix_runtime_irq}, 32'h6);
        bus_clk_stopped <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({29'h0, matrix_wake_irq, matrix_wake_request, matrix_runtime_irq}, 32'h1);
        $display("wake test done");
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h40);
        xfer(`KMS_OFS_EXT_CTL, 1'b1, 32'h1);
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h00);
        repeat (6) @(posedge hclk);
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h01);
        seen = 0;
        repeat (6) begin
            @(posedge hclk);
            if (row_drive_oe[0] === 1'b1 && row_drive_out[0] === 1'b1) seen = seen + 1;
        end
        chk(seen, 32'h3);
        chk({14'h0, row_drive_oe}, 32'h2);
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h41);
        xfer(`KMS_OFS_EXT_CTL, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        chk({13'h0, row_drive_oe, sleep_inhibit}, 32'h0);
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h01);
        repeat (2) @(posedge hclk);
        chk({14'h0, row_drive_oe}, 32'h2);
        clk_en <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({30'h0, hreadyout, hresp}, 32'h0);
        clk_en <= 1'b1;
        $display("predrive test done");
        xfer(`KMS_OFS_ROW_SEL, 1'b1, 32'h00);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({14'h0, row_drive_oe}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(`KMS_OFS_ROW_SEL, 1'b0, 32'h0);
        chk(q, 32'h40);
        $display("second reset done");
        conclude;
    end
endmodule
